// ### lss_defs.vh
// Summary of operation
// - Each port has its own counter of time since its last master message.
// - Four counters: first, second, third serial port and the wireless port.
// - A message received from the master clears that port's counter to zero.
// - After clearing, the counter advances by one every second until the next message or until it reaches 32767.
// - Counter values are seconds, ranging from 0 to 32767.
// - Master requests are served with no user program loaded.
// - Output points stay off, even against master writes, unless in run state.
// - Requests arriving over TCP are served only while the TCP server is enabled.
// - A port set to ASCII protocol offers no advanced timing parameters.
`ifndef LSS_DEFS_VH
`define LSS_DEFS_VH

`define LSS_NUM_PORTS      4
`define LSS_CNT_W          16
`define LSS_CNT_MAX        16'h7FFF
`define LSS_TICK_PERIOD_S  1
`define LSS_MCLK_HZ        10000000
`define LSS_TICK_CYCLES    (`LSS_TICK_PERIOD_S * `LSS_MCLK_HZ)

`define LSS_ADDR_W         8
`define LSS_OFF_CNT0       8'h00
`define LSS_OFF_CNT1       8'h04
`define LSS_OFF_CNT2       8'h08
`define LSS_OFF_CNT3       8'h0C
`define LSS_OFF_CTRL       8'h10
`define LSS_OFF_THRESH     8'h14
`define LSS_OFF_OUTREQ     8'h18
`define LSS_OFF_STATUS     8'h1C
`define LSS_OFF_MASK       8'h20
`define LSS_OFF_STATE      8'h24

`define LSS_CTRL_TCPEN_BIT 0
`define LSS_CTRL_ASCII_LSB 4
`define LSS_THRESH_RESET   16'h003C
`define LSS_OUT_W          16

`define LSS_RESP_OKAY      2'h0
`define LSS_RESP_DECERR    2'h3

`endif

// ### lss_silence_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "lss_defs.vh"

module lss_silence_counter #(
  parameter             CNT_W   = `LSS_CNT_W,
  parameter [CNT_W-1:0] CNT_MAX = `LSS_CNT_MAX
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire             clkEn,
  input  wire             msgSeen,
  input  wire             secTick,
  output reg  [CNT_W-1:0] count_ff
);

  reg [CNT_W-1:0] nxt_count;

  always @* begin
    nxt_count = count_ff;
    if (msgSeen) begin
      // A message in the tick cycle still restarts from zero
      nxt_count = {CNT_W{1'b0}};
    end else if (secTick && (count_ff < CNT_MAX)) begin
      nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      count_ff <= {CNT_W{1'b0}};
    end else if (clkEn) begin
      count_ff <= nxt_count;
    end
  end

endmodule
`default_nettype wire

// ### lss_link_silence_timers.v
`timescale 1ns/100ps
`default_nettype none
`include "lss_defs.vh"

module lss_link_silence_timers #(
  parameter NPORT       = `LSS_NUM_PORTS,
  parameter CNT_W       = `LSS_CNT_W,
  parameter TICK_CYCLES = `LSS_TICK_CYCLES,
  parameter PRE_W       = 24
) (
  input  wire                 mclk,
  input  wire                 reset,
  input  wire                 clkEn,
  input  wire [NPORT-1:0]     msgRx,
  input  wire                 msgIsTcp,
  input  wire                 runMode,
  output reg  [NPORT-1:0]     serveReq_ff,
  output reg  [`LSS_OUT_W-1:0] outPoints_ff,
  output reg  [NPORT-1:0]     advTimingAvail_ff,
  output wire                 irq,
  input  wire [`LSS_ADDR_W-1:0] s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [`LSS_ADDR_W-1:0] s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready
);

  localparam integer     TICK_LAST_I = TICK_CYCLES - 1;
  localparam [PRE_W-1:0] TICK_LAST   = TICK_LAST_I[PRE_W-1:0];

  // One-second time base
  reg  [PRE_W-1:0]        preCnt_ff;
  reg                     secTick_ff;
  // Software registers
  reg                     tcpServerEn_ff;
  reg  [NPORT-1:0]        asciiMode_ff;
  reg  [CNT_W-1:0]        thresh_ff;
  reg  [`LSS_OUT_W-1:0]   outReq_ff;
  reg  [2*NPORT-1:0]      status_ff;
  reg  [2*NPORT-1:0]      mask_ff;
  reg  [NPORT-1:0]        atThresh_ff;
  // Write channel holding
  reg                     awHeld_ff;
  reg  [`LSS_ADDR_W-1:0]  awAddr_ff;
  reg                     wHeld_ff;
  reg  [31:0]             wData_ff;
  reg  [3:0]              wStrb_ff;

  wire [NPORT-1:0]        accepted;
  wire [CNT_W*NPORT-1:0]  countFlat;
  wire [NPORT-1:0]        atThresh;
  wire [NPORT-1:0]        timeoutEvt;
  wire                    doWrite;
  wire                    wrCtrl;
  wire                    wrThresh;
  wire                    wrOutReq;
  wire                    wrStatus;
  wire                    wrMask;
  wire                    wrMapped;
  reg  [2*NPORT-1:0]      nxt_status;
  reg  [31:0]             rdWord;
  reg                     rdHit;

  always @(posedge mclk) begin
    if (reset) begin
      preCnt_ff  <= {PRE_W{1'b0}};
      secTick_ff <= 1'b0;
    end else if (clkEn) begin
      secTick_ff <= (preCnt_ff == TICK_LAST);
      if (preCnt_ff == TICK_LAST) begin
        preCnt_ff <= {PRE_W{1'b0}};
      end else begin
        preCnt_ff <= preCnt_ff + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : gPort
      // Only the first port carries TCP traffic; a disabled server drops it
      if (gi == 0) begin : gTcp
        assign accepted[gi] = msgRx[gi] & (~msgIsTcp | tcpServerEn_ff);
      end else begin : gSer
        assign accepted[gi] = msgRx[gi];
      end

      lss_silence_counter #(
        .CNT_W   (CNT_W),
        .CNT_MAX (`LSS_CNT_MAX)
      ) uCnt (
        .mclk     (mclk),
        .reset    (reset),
        .clkEn    (clkEn),
        .msgSeen  (accepted[gi]),
        .secTick  (secTick_ff),
        .count_ff (countFlat[gi*CNT_W +: CNT_W])
      );

      assign atThresh[gi]   = (countFlat[gi*CNT_W +: CNT_W] == thresh_ff);
      assign timeoutEvt[gi] = atThresh[gi] & ~atThresh_ff[gi];
    end
  endgenerate

  // Serving a request needs a configured port only, never the run state
  always @(posedge mclk) begin
    if (reset) begin
      serveReq_ff       <= {NPORT{1'b0}};
      advTimingAvail_ff <= {NPORT{1'b0}};
      outPoints_ff      <= {`LSS_OUT_W{1'b0}};
      atThresh_ff       <= {NPORT{1'b1}};
    end else if (clkEn) begin
      serveReq_ff       <= accepted;
      advTimingAvail_ff <= ~asciiMode_ff;
      outPoints_ff      <= runMode ? outReq_ff : {`LSS_OUT_W{1'b0}};
      atThresh_ff       <= atThresh;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  // Readies drop while frozen, else a handshake would be lost
  assign s_axi_awready = clkEn & ~awHeld_ff & ~s_axi_bvalid;
  assign s_axi_wready  = clkEn & ~wHeld_ff & ~s_axi_bvalid;
  assign doWrite       = awHeld_ff & wHeld_ff & ~s_axi_bvalid;

  assign wrCtrl   = doWrite & (awAddr_ff == `LSS_OFF_CTRL);
  assign wrThresh = doWrite & (awAddr_ff == `LSS_OFF_THRESH);
  assign wrOutReq = doWrite & (awAddr_ff == `LSS_OFF_OUTREQ);
  assign wrStatus = doWrite & (awAddr_ff == `LSS_OFF_STATUS);
  assign wrMask   = doWrite & (awAddr_ff == `LSS_OFF_MASK);
  assign wrMapped = wrCtrl | wrThresh | wrOutReq | wrStatus | wrMask |
                    (awAddr_ff == `LSS_OFF_CNT0) | (awAddr_ff == `LSS_OFF_CNT1) |
                    (awAddr_ff == `LSS_OFF_CNT2) | (awAddr_ff == `LSS_OFF_CNT3) |
                    (awAddr_ff == `LSS_OFF_STATE);

  always @(posedge mclk) begin
    if (reset) begin
      awHeld_ff    <= 1'b0;
      awAddr_ff    <= {`LSS_ADDR_W{1'b0}};
      wHeld_ff     <= 1'b0;
      wData_ff     <= 32'h00000000;
      wStrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LSS_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= {s_axi_awaddr[`LSS_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff    <= 1'b0;
        wHeld_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `LSS_RESP_OKAY : `LSS_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      tcpServerEn_ff <= 1'b0;
      asciiMode_ff   <= {NPORT{1'b0}};
      thresh_ff      <= `LSS_THRESH_RESET;
      outReq_ff      <= {`LSS_OUT_W{1'b0}};
      mask_ff        <= {2*NPORT{1'b0}};
    end else if (clkEn) begin
      if (wrCtrl && wStrb_ff[0]) begin
        tcpServerEn_ff <= wData_ff[`LSS_CTRL_TCPEN_BIT];
        asciiMode_ff   <= wData_ff[`LSS_CTRL_ASCII_LSB +: NPORT];
      end
      if (wrThresh) begin
        if (wStrb_ff[0]) thresh_ff[7:0] <= wData_ff[7:0];
        if (wStrb_ff[1]) thresh_ff[CNT_W-1:8] <= wData_ff[CNT_W-1:8];
      end
      if (wrOutReq) begin
        if (wStrb_ff[0]) outReq_ff[7:0] <= wData_ff[7:0];
        if (wStrb_ff[1]) outReq_ff[`LSS_OUT_W-1:8] <= wData_ff[`LSS_OUT_W-1:8];
      end
      if (wrMask && wStrb_ff[0]) begin
        mask_ff <= wData_ff[2*NPORT-1:0];
      end
    end
  end

  // Sticky events: low half timeout reached, high half message accepted.
  // A new event in the clearing cycle survives the write-one-to-clear.
  always @* begin
    nxt_status = status_ff;
    if (wrStatus && wStrb_ff[0]) begin
      nxt_status = nxt_status & ~wData_ff[2*NPORT-1:0];
    end
    nxt_status = nxt_status | {accepted, timeoutEvt};
  end

  always @(posedge mclk) begin
    if (reset) begin
      status_ff <= {2*NPORT{1'b0}};
    end else if (clkEn) begin
      status_ff <= nxt_status;
    end
  end

  assign irq = |(status_ff & mask_ff);

  // AXI4-Lite read: one outstanding, answered the edge after acceptance
  assign s_axi_arready = clkEn & ~s_axi_rvalid;

  always @* begin
    rdWord = 32'h00000000;
    rdHit  = 1'b1;
    case ({s_axi_araddr[`LSS_ADDR_W-1:2], 2'b00})
      `LSS_OFF_CNT0: begin
        rdWord[CNT_W-1:0] = countFlat[0*CNT_W +: CNT_W];
      end
      `LSS_OFF_CNT1: begin
        rdWord[CNT_W-1:0] = countFlat[1*CNT_W +: CNT_W];
      end
      `LSS_OFF_CNT2: begin
        rdWord[CNT_W-1:0] = countFlat[2*CNT_W +: CNT_W];
      end
      `LSS_OFF_CNT3: begin
        rdWord[CNT_W-1:0] = countFlat[3*CNT_W +: CNT_W];
      end
      `LSS_OFF_CTRL: begin
        rdWord[`LSS_CTRL_TCPEN_BIT]          = tcpServerEn_ff;
        rdWord[`LSS_CTRL_ASCII_LSB +: NPORT] = asciiMode_ff;
      end
      `LSS_OFF_THRESH: begin
        rdWord[CNT_W-1:0] = thresh_ff;
      end
      `LSS_OFF_OUTREQ: begin
        rdWord[`LSS_OUT_W-1:0] = outReq_ff;
      end
      `LSS_OFF_STATUS: begin
        rdWord[2*NPORT-1:0] = status_ff;
      end
      `LSS_OFF_MASK: begin
        rdWord[2*NPORT-1:0] = mask_ff;
      end
      `LSS_OFF_STATE: begin
        rdWord[0]                 = runMode;
        rdWord[`LSS_OUT_W:1]      = outPoints_ff;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `LSS_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdHit ? `LSS_RESP_OKAY : `LSS_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### lss_timers_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "lss_defs.vh"
module lss_timers_props #(
  parameter NPORT = `LSS_NUM_PORTS
) (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  clkEn,
  input wire logic [NPORT-1:0]      msgRx,
  input wire logic                  runMode,
  input wire logic [NPORT-1:0]      serveReq_ff,
  input wire logic [`LSS_OUT_W-1:0] outPoints_ff,
  input wire logic                  irq,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Port 0 is left out here because a TCP message may be dropped
  a_serve_msg: assert property (msgRx[NPORT-1:1] != 0 |=> serveReq_ff[NPORT-1:1] == $past(msgRx[NPORT-1:1]))
    else $error("serve request does not follow message");
  a_serve_cause: assert property (serveReq_ff[0] |-> $past(msgRx[0]))
    else $error("port 0 served without message");
  a_out_gated: assert property (!$past(runMode) |-> outPoints_ff == 0)
    else $error("outputs on outside run state");
  a_ar_ready: assert property (s_axi_arready == (clkEn && !s_axi_rvalid))
    else $error("arready not inverse of rvalid");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_irq_reset: assert property ($past(reset) |-> !irq)
    else $error("irq high after reset");
  c_msg: cover property (msgRx != 0);
  c_irq: cover property (irq);
  c_bresp: cover property (s_axi_bvalid);
endmodule
bind lss_link_silence_timers lss_timers_props #(.NPORT(NPORT)) lss_timers_props_inst (
  .mclk(mclk), .reset(reset), .clkEn(clkEn), .msgRx(msgRx), .runMode(runMode), .serveReq_ff(serveReq_ff),
  .outPoints_ff(outPoints_ff), .irq(irq), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// ### lss_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module lss_master_model (
  input  wire logic       mclk,
  output var  logic [3:0] msgRx,
  output var  logic       msgIsTcp
);
  initial begin
    msgRx = 4'h0;
    msgIsTcp = 1'b0;
  end
  task send(input integer p, input logic tcp);
    @(posedge mclk);
    msgRx <= 4'h1 << p;
    msgIsTcp <= tcp;
    @(posedge mclk);
    msgRx <= 4'h0;
    // Inverse of the last qualifier so a stale level never looks valid
    msgIsTcp <= ~tcp;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lss_defs.vh"
module tb_top;
  localparam TK = 2;
  logic        mclk = 0, reset = 1, runMode = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v, v2;
  logic [3:0]  msgRx, serveReq_ff, advTimingAvail_ff;
  logic        msgIsTcp, irq, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, aok, wok, ok;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] outPoints_ff, lf = 16'hB4B0;
  integer      n_errors = 0, check_count = 0, i, j, k, c;
  always #50 mclk = ~mclk;
  // Short tick period keeps saturation reachable within the run
  lss_link_silence_timers #(.TICK_CYCLES(TK)) lss_link_silence_timers_inst (
    .mclk(mclk), .reset(reset), .clkEn(1'b1), .msgRx(msgRx), .msgIsTcp(msgIsTcp), .runMode(runMode),
    .serveReq_ff(serveReq_ff), .outPoints_ff(outPoints_ff), .advTimingAvail_ff(advTimingAvail_ff), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  lss_master_model lss_master_model_inst (.mclk(mclk), .msgRx(msgRx), .msgIsTcp(msgIsTcp));
  function logic [15:0] rnd(input logic [15:0] s);
    rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [15:0] exp_out(input logic r, input logic [15:0] q);
    exp_out = r ? q : 16'h0000;
  endfunction
  task check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      n_errors++;
    end
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task tmo(input logic done);
    if (!done) begin
      n_errors++;
      conclude;
    end
  endtask
  // Readies are looked at mid-cycle; inputs only move on rising edges
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    ok = 0;
    for (c = 0; c < 40 && !ok; c++) begin
      @(negedge mclk);
      aok = awready & awvalid;
      wok = wready & wvalid;
      ok = bvalid === 1'b1;
      rs = bresp;
      @(posedge mclk);
      if (aok === 1'b1) awvalid <= 0;
      if (wok === 1'b1) wvalid <= 0;
      if (ok) bready <= 0;
    end
    tmo(ok);
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    ok = 0;
    for (c = 0; c < 40 && !ok; c++) begin
      @(negedge mclk);
      aok = arready & arvalid;
      ok = rvalid === 1'b1;
      v = rdata;
      rs = rresp;
      @(posedge mclk);
      if (aok === 1'b1) arvalid <= 0;
      if (ok) rready <= 0;
    end
    tmo(ok);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 0;
    rd(`LSS_OFF_THRESH);
    check(v, {16'h0000, `LSS_THRESH_RESET});
    rd(8'h28);
    check({30'h0, rs}, {30'h0, `LSS_RESP_DECERR});
    wr(8'h30, 32'h1);
    check({30'h0, rs}, {30'h0, `LSS_RESP_DECERR});
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      lf = rnd(lf);
      k = 5 + lf[3:0];
      rd({i[5:0], 2'b00});
      v2 = v;
      repeat (2 * k - 3) @(posedge mclk);
      rd({i[5:0], 2'b00});
      check(v - v2, k);
    end
    $display("test seconds done");
    for (i = 0; i < 3; i++) begin
      lss_master_model_inst.send(i, 0);
      @(negedge mclk);
      check({28'h0, serveReq_ff}, 32'h1 << i);
      for (j = 0; j < 4; j++) begin
        k = (i + j) % 4;
        rd({k[5:0], 2'b00});
        if (j == 0) check({31'h0, v[15:0] <= 16'h0001}, 32'h1);
        else check({31'h0, v[15:0] > 16'h0003}, 32'h1);
      end
    end
    $display("test ports done");
    lss_master_model_inst.send(0, 1);
    @(negedge mclk);
    check({28'h0, serveReq_ff}, 32'h0);
    rd(`LSS_OFF_CNT0);
    check({31'h0, v[15:0] > 16'h0003}, 32'h1);
    wr(`LSS_OFF_CTRL, 32'h1);
    lss_master_model_inst.send(0, 1);
    @(negedge mclk);
    check({28'h0, serveReq_ff}, 32'h1);
    rd(`LSS_OFF_CNT0);
    check({31'h0, v[15:0] <= 16'h0001}, 32'h1);
    $display("test tcp done");
    for (i = 0; i < 4; i++) begin
      lf = rnd(lf);
      wr(`LSS_OFF_CTRL, {24'h0, lf[7:4], 4'h0});
      @(negedge mclk);
      check({28'h0, advTimingAvail_ff}, {28'h0, ~lf[7:4]});
      @(posedge mclk);
      runMode <= i[0];
      wr(`LSS_OFF_OUTREQ, lf);
      @(negedge mclk);
      check({16'h0, outPoints_ff}, {16'h0, exp_out(runMode, lf)});
      rd(`LSS_OFF_STATE);
      check(v, {15'h0, exp_out(runMode, lf), runMode});
    end
    $display("test outputs done");
    wr(`LSS_OFF_MASK, 32'h10);
    wr(`LSS_OFF_STATUS, 32'hFF);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    lss_master_model_inst.send(0, 0);
    @(negedge mclk);
    check({31'h0, irq}, 32'h1);
    wr(`LSS_OFF_STATUS, 32'h10);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    wr(`LSS_OFF_MASK, 32'h0);
    lss_master_model_inst.send(0, 0);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    $display("test irq done");
    repeat (66000) @(posedge mclk);
    rd(`LSS_OFF_CNT3);
    check(v, {16'h0, `LSS_CNT_MAX});
    repeat (50) @(posedge mclk);
    rd(`LSS_OFF_CNT3);
    check(v, {16'h0, `LSS_CNT_MAX});
    lss_master_model_inst.send(3, 0);
    rd(`LSS_OFF_CNT3);
    check({31'h0, v[15:0] <= 16'h0001}, 32'h1);
    $display("test saturation done");
    conclude;
  end
endmodule
`default_nettype wire
